// ==== rtl/timer_control_irq_mask.sv ====
// Watchdog and interval timer control, status flags and interrupt masking
// Behaviour
// - Mask bit 11 forwards the watchdog status flag onto the timer interrupt.
// - Mask bits 3:0 forward each channel status flag onto the timer interrupt.
// - Timer interrupt reaches the processor only with system enable set.
// - Control bits 14:11 run channels 3..0; a cleared bit holds the channel.
// - Control bit 8 picks interrupt (1) or system reset (0) on time-out.
// - Control bit 5 picks 32 KHz clock (1) or system clock (0).
// - Clock select becomes 1 on power-up reset only.
// - Once enabled, clock select and reset scope bits are frozen.
// - Control bit 4 limits watchdog clearing to power-up or watchdog resets.
// - Reset scope bit becomes 0 on power-up reset only.
// - Control bit 3 starts the watchdog and can never be cleared by writes.
// - Writing 0xfade to watchdog count clears it; software does so periodically.
// - Watchdog reaching its maximum signals time-out, interrupt or reset.
// - Watchdog flag sets on time-out in interrupt mode; write 1 clears.
// - Channel flag sets when its count reaches zero; write 1 clears.
// - Tick rate is system clock divided by 2^(code+1), codes 0..11.
`timescale 1ns/1ps
`default_nettype none

module timer_control_irq_mask
    import timer_ctrl_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int CNT_W    = 16
) (
    // Clock and resets
    input  wire logic                clock,
    input  wire logic                reset_n,
    input  wire logic                por_n,
    input  wire logic                reset_by_wdog,
    // Register port
    input  wire reg_req_t            reg_req,
    output logic [31:0]              rd_data,
    // Slow clock and interrupt controller
    input  wire logic                slow_clk_in,
    input  wire logic                sys_irq_enable,
    // Status towards the system
    output logic                     timer_irq_req,
    output logic                     timer_irq,
    output logic                     wdog_reset_req,
    output logic [CHANNELS-1:0]      chan_run_enable
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    logic                 any_reset;
    logic                 wdog_clear;
    logic                 wr_rate;
    logic                 wr_wdog_cnt;
    logic                 wr_status;
    logic                 wr_mask;
    logic                 wr_ctrl;
    timer_ctrl_t          ctrl_q;
    logic [3:0]           chan_code_q;
    logic [3:0]           wdog_code_q;
    logic [CNT_W-1:0]     wdog_count_q;
    logic                 wdog_flag_q;
    logic                 wdog_mask_q;
    logic [CHANNELS-1:0]  chan_flag_q;
    logic [CHANNELS-1:0]  chan_mask_q;
    logic [11:0]          div_q;
    logic                 slow_meta_q;
    logic                 slow_sync_q;
    logic                 slow_prev_q;
    logic                 chan_tick;
    logic                 wdog_tick;
    logic                 wdog_timeout;
    logic [CNT_W-1:0]     max_q [CHANNELS];
    logic [CNT_W-1:0]     cnt_q [CHANNELS];
    logic [CHANNELS-1:0]  max_wr;
    logic [CHANNELS-1:0]  expire;

    // Any reset source clears ordinary state
    assign any_reset   = !reset_n || !por_n;
    // Watchdog survives a plain reset when the scope bit says so
    assign wdog_clear  = !por_n || (!reset_n &&
                         (!ctrl_q.wdog_reset_scope || reset_by_wdog));
    assign wr_rate     = reg_req.wr_en && reg_req.addr == ADDR_COUNT_RATE;
    assign wr_wdog_cnt = reg_req.wr_en && reg_req.addr == ADDR_WDOG_COUNT;
    assign wr_status   = reg_req.wr_en && reg_req.addr == ADDR_STATUS;
    assign wr_mask     = reg_req.wr_en && reg_req.addr == ADDR_IRQ_MASK;
    assign wr_ctrl     = reg_req.wr_en && reg_req.addr == ADDR_CONTROL;

    ////////////////////////////////////////////////////////////////////////////
    // Control register
    // Power-up-only fields; frozen once the watchdog runs
    always_ff @(posedge clock) begin
        if (!por_n) begin
            ctrl_q.wdog_clock_select <= CLKSEL_POR;
            ctrl_q.wdog_reset_scope  <= SCOPE_POR;
        end else if (wr_ctrl && !ctrl_q.wdog_enable_lock) begin
            ctrl_q.wdog_clock_select <= reg_req.wr_data[CTL_CLKSEL_BIT];
            ctrl_q.wdog_reset_scope  <= reg_req.wr_data[CTL_SCOPE_BIT];
        end
    end
    // Channel enables and time-out action follow every reset
    always_ff @(posedge clock) begin
        if (any_reset) begin
            ctrl_q.chan_run_enable    <= '0;
            ctrl_q.wdog_action_select <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_q.chan_run_enable    <= reg_req.wr_data[CTL_RUN_LSB +: 4];
            ctrl_q.wdog_action_select <= reg_req.wr_data[CTL_ACTION_BIT];
        end
    end
    // Enable is set-only; only the watchdog's own clearing drops it
    always_ff @(posedge clock) begin
        if (wdog_clear) begin
            ctrl_q.wdog_enable_lock <= 1'b0;
        end else if (wr_ctrl && reg_req.wr_data[CTL_ENABLE_BIT]) begin
            ctrl_q.wdog_enable_lock <= 1'b1;
        end
    end

    assign chan_run_enable = ctrl_q.chan_run_enable[CHANNELS-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Rate codes and tick generation
    // Watchdog rate is frozen with the enable, like its clock select
    always_ff @(posedge clock) begin
        if (any_reset) begin
            chan_code_q <= 4'h0;
        end else if (wr_rate) begin
            chan_code_q <= reg_req.wr_data[RATE_CHAN_LSB +: 4];
        end
    end

    always_ff @(posedge clock) begin
        if (wdog_clear) begin
            wdog_code_q <= 4'h0;
        end else if (wr_rate && !ctrl_q.wdog_enable_lock) begin
            wdog_code_q <= reg_req.wr_data[RATE_WDOG_LSB +: 4];
        end
    end
    // Free-running divider shared by all rates
    always_ff @(posedge clock) begin
        if (any_reset) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 12'h001;
        end
    end
    // Slow clock synchroniser and edge history
    always_ff @(posedge clock) begin
        if (any_reset) begin
            slow_meta_q <= 1'b0;
            slow_sync_q <= 1'b0;
            slow_prev_q <= 1'b0;
        end else begin
            slow_meta_q <= slow_clk_in;
            slow_sync_q <= slow_meta_q;
            slow_prev_q <= slow_sync_q;
        end
    end
    // Reserved codes behave as the slowest rate rather than stopping the count
    function automatic logic rate_tick(input logic [11:0] div, input logic [3:0] code);
        logic [3:0]  c;
        logic [12:0] m;
        c = (code > RATE_CODE_MAX) ? RATE_CODE_MAX : code;
        m = (13'h0001 << (c + 4'h1)) - 13'h0001;
        return (div & m[11:0]) == m[11:0];
    endfunction
    assign chan_tick = rate_tick(div_q, chan_code_q);
    assign wdog_tick = ctrl_q.wdog_clock_select ?
                       (slow_sync_q && !slow_prev_q) : rate_tick(div_q, wdog_code_q);

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog counter
    assign wdog_timeout   = ctrl_q.wdog_enable_lock && wdog_count_q == WDOG_MAX_COUNT;
    assign wdog_reset_req = wdog_timeout && !ctrl_q.wdog_action_select;
    // Holds at maximum until restarted, so the time-out stays asserted
    always_ff @(posedge clock) begin
        if (wdog_clear) begin
            wdog_count_q <= '0;
        end else if (wr_wdog_cnt && reg_req.wr_data[CNT_W-1:0] == WDOG_RESTART) begin
            wdog_count_q <= '0;
        end else if (ctrl_q.wdog_enable_lock && wdog_tick && !wdog_timeout) begin
            wdog_count_q <= wdog_count_q + COUNT_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interval channels
    generate
        for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
            localparam logic [31:0] MAX_ADDR = ADDR_CHAN_BASE + CHAN_STRIDE * i;

            assign max_wr[i] = reg_req.wr_en && reg_req.addr == MAX_ADDR;
            assign expire[i] = chan_run_enable[i] && chan_tick && cnt_q[i] == COUNT_ONE;

            always_ff @(posedge clock) begin
                if (any_reset) begin
                    max_q[i] <= '0;
                end else if (max_wr[i]) begin
                    max_q[i] <= reg_req.wr_data[CNT_W-1:0];
                end
            end
            // A write of the maximum beats a tick in the same cycle
            always_ff @(posedge clock) begin
                if (any_reset) begin
                    cnt_q[i] <= '0;
                end else if (max_wr[i]) begin
                    cnt_q[i] <= reg_req.wr_data[CNT_W-1:0];
                end else if (chan_run_enable[i] && chan_tick) begin
                    cnt_q[i] <= (cnt_q[i] == COUNT_ZERO) ? max_q[i] : cnt_q[i] - COUNT_ONE;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Status flags and masks
    // Set wins over a write-1 clear in the same cycle
    always_ff @(posedge clock) begin
        if (any_reset) begin
            wdog_flag_q <= 1'b0;
            chan_flag_q <= '0;
        end else begin
            wdog_flag_q <= (wdog_timeout && ctrl_q.wdog_action_select) ||
                           (wdog_flag_q && !(wr_status && reg_req.wr_data[WDOG_FLAG_BIT]));
            chan_flag_q <= expire |
                           (chan_flag_q & ~({CHANNELS{wr_status}} &
                                            reg_req.wr_data[CHANNELS-1:0]));
        end
    end

    always_ff @(posedge clock) begin
        if (any_reset) begin
            wdog_mask_q <= 1'b0;
            chan_mask_q <= '0;
        end else if (wr_mask) begin
            wdog_mask_q <= reg_req.wr_data[WDOG_FLAG_BIT];
            chan_mask_q <= reg_req.wr_data[CHANNELS-1:0];
        end
    end
    // Shared request and the system-level gate
    assign timer_irq_req = (wdog_flag_q && wdog_mask_q) ||
                           |(chan_flag_q & chan_mask_q);
    assign timer_irq     = timer_irq_req && sys_irq_enable;

    ////////////////////////////////////////////////////////////////////////////
    // Read port
    // Data stand only in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clock) begin
        if (any_reset || !reg_req.rd_en) begin
            rd_data <= '0;
        end else begin
            rd_data <= '0;
            case (reg_req.addr)
                ADDR_COUNT_RATE: begin
                    rd_data[RATE_CHAN_LSB +: 4] <= chan_code_q;
                    rd_data[RATE_WDOG_LSB +: 4] <= wdog_code_q;
                end
                ADDR_WDOG_COUNT: rd_data[CNT_W-1:0] <= wdog_count_q;
                ADDR_STATUS: begin
                    rd_data[WDOG_FLAG_BIT]  <= wdog_flag_q;
                    rd_data[CHANNELS-1:0]   <= chan_flag_q;
                end
                ADDR_IRQ_MASK: begin
                    rd_data[WDOG_FLAG_BIT]  <= wdog_mask_q;
                    rd_data[CHANNELS-1:0]   <= chan_mask_q;
                end
                ADDR_CONTROL: begin
                    rd_data[CTL_RUN_LSB +: 4]  <= ctrl_q.chan_run_enable;
                    rd_data[CTL_ACTION_BIT]    <= ctrl_q.wdog_action_select;
                    rd_data[CTL_CLKSEL_BIT]    <= ctrl_q.wdog_clock_select;
                    rd_data[CTL_SCOPE_BIT]     <= ctrl_q.wdog_reset_scope;
                    rd_data[CTL_ENABLE_BIT]    <= ctrl_q.wdog_enable_lock;
                end
                default: begin
                    for (int k = 0; k < CHANNELS; k++) begin
                        if (reg_req.addr == ADDR_CHAN_BASE + CHAN_STRIDE * k) begin
                            rd_data[CNT_W-1:0] <= max_q[k];
                        end
                        if (reg_req.addr == ADDR_CHAN_BASE + CHAN_STRIDE * k + CHAN_COUNT_OFS) begin
                            rd_data[CNT_W-1:0] <= cnt_q[k];   // current_count
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (any_reset);

    a_wdog_mask_gate:
        assert property (wdog_flag_q && wdog_mask_q |-> timer_irq_req)
        else $error("watchdog flag with mask set did not raise request");
    a_chan_mask_gate:
        assert property (!wdog_flag_q && (chan_flag_q & chan_mask_q) == '0 |-> !timer_irq_req)
        else $error("request raised with every source masked");
    a_sys_irq_gate:
        assert property (timer_irq |-> sys_irq_enable && timer_irq_req)
        else $error("timer interrupt without system enable");
    a_chan_hold:
        assert property (!chan_run_enable[0] && !max_wr[0] |=> $stable(cnt_q[0]))
        else $error("disabled channel changed its count");
    a_action_reset:
        assert property (wdog_timeout && !ctrl_q.wdog_action_select |-> wdog_reset_req)
        else $error("time-out in reset mode without reset request");
    a_lock_freeze:
        assert property (ctrl_q.wdog_enable_lock && por_n |=>
                         $stable(ctrl_q.wdog_clock_select) && $stable(ctrl_q.wdog_reset_scope))
        else $error("locked watchdog field changed");
    a_enable_sticky:
        assert property (ctrl_q.wdog_enable_lock |=> ctrl_q.wdog_enable_lock)
        else $error("watchdog enable dropped without reset");
    a_restart_clear:
        assert property (wr_wdog_cnt && reg_req.wr_data[CNT_W-1:0] == WDOG_RESTART
                         |=> wdog_count_q == '0)
        else $error("restart value did not clear watchdog count");
    a_wdog_flag_set:
        assert property (wdog_timeout && ctrl_q.wdog_action_select |=> wdog_flag_q)
        else $error("interrupt-mode time-out did not set flag");
    a_max_load:
        assert property (max_wr[0] |=> cnt_q[0] == $past(reg_req.wr_data[CNT_W-1:0]))
        else $error("maximum write did not load count");
    a_por_values:
        assert property (@(posedge clock) disable iff (1'b0) !por_n |=>
                         ctrl_q.wdog_clock_select && !ctrl_q.wdog_reset_scope)
        else $error("power-up values wrong");
    c_restart:   cover property (wr_wdog_cnt && ctrl_q.wdog_enable_lock);
    c_wdog_flag: cover property (wdog_flag_q && wdog_mask_q);
    c_chan_exp:  cover property (expire[0] ##1 timer_irq);

endmodule

`default_nettype wire

// ==== rtl/timer_ctrl_pkg.sv ====
// Register map, field positions and carrier types of the timer control block
package timer_ctrl_pkg;

    // Byte addresses of the registers
    localparam logic [31:0] ADDR_COUNT_RATE = 32'he000_5018;
    localparam logic [31:0] ADDR_WDOG_COUNT = 32'he000_501c;
    localparam logic [31:0] ADDR_STATUS     = 32'he000_5024;
    localparam logic [31:0] ADDR_IRQ_MASK   = 32'he000_5028;
    localparam logic [31:0] ADDR_CONTROL    = 32'he000_502c;
    localparam logic [31:0] ADDR_CHAN_BASE  = 32'he000_5030;
    localparam logic [31:0] CHAN_STRIDE     = 32'h0000_0008;
    localparam logic [31:0] CHAN_COUNT_OFS  = 32'h0000_0004;

    // Control register fields
    localparam int CTL_RUN_LSB    = 11;
    localparam int CTL_ACTION_BIT = 8;
    localparam int CTL_CLKSEL_BIT = 5;
    localparam int CTL_SCOPE_BIT  = 4;
    localparam int CTL_ENABLE_BIT = 3;

    // Status and mask fields
    localparam int WDOG_FLAG_BIT = 11;

    // Count rate fields
    localparam int RATE_CHAN_LSB = 8;
    localparam int RATE_WDOG_LSB = 4;

    // Rate codes and counter constants
    localparam logic [3:0]  RATE_CODE_MAX  = 4'hb;
    localparam logic [15:0] WDOG_RESTART   = 16'hfade;
    localparam logic [15:0] WDOG_MAX_COUNT = 16'hffff;
    localparam logic [15:0] COUNT_ZERO     = 16'h0000;
    localparam logic [15:0] COUNT_ONE      = 16'h0001;

    // Reset values
    localparam logic CLKSEL_POR = 1'b1;
    localparam logic SCOPE_POR  = 1'b0;

    // Control register contents
    typedef struct packed {
        logic [3:0] chan_run_enable;
        logic       wdog_action_select;
        logic       wdog_clock_select;
        logic       wdog_reset_scope;
        logic       wdog_enable_lock;
    } timer_ctrl_t;

    // Register bus request
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wr_data;
        logic        wr_en;
        logic        rd_en;
    } reg_req_t;

endpackage

// ==== sim/timer_control_irq_mask_tb_top.sv ====
// Self-checking bench for the timer control and interrupt masking block
`timescale 1ns/1ps
`default_nettype none

module timer_control_irq_mask_tb_top
    import timer_ctrl_pkg::*;
;

    ////////////////////////////////////////////////////////////////////////////////
    // Signals
    logic        clock;
    logic        reset_n;
    logic        por_n;
    logic        reset_by_wdog;
    reg_req_t    reg_req;
    logic [31:0] rd_data;
    logic        slow_clk_in;
    logic        sys_irq_enable;
    logic        timer_irq_req;
    logic        timer_irq;
    logic        wdog_reset_req;
    logic [3:0]  chan_run_enable;
    logic [4:0]  slow_div_q;
    int          err_total;
    int          tests_run;
    logic [31:0] got;
    logic [31:0] mask_model;

    timer_control_irq_mask #(
        .CHANNELS (4),
        .CNT_W    (16)
    ) u_dut (
        .clock           (clock),
        .reset_n         (reset_n),
        .por_n           (por_n),
        .reset_by_wdog   (reset_by_wdog),
        .reg_req         (reg_req),
        .rd_data         (rd_data),
        .slow_clk_in     (slow_clk_in),
        .sys_irq_enable  (sys_irq_enable),
        .timer_irq_req   (timer_irq_req),
        .timer_irq       (timer_irq),
        .wdog_reset_req  (wdog_reset_req),
        .chan_run_enable (chan_run_enable)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clocks: system clock at 4 ns, slow clock as a divided level
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Slow clock stands in for the 32 KHz source, much faster to keep the run short
    initial begin
        slow_div_q  = 5'h00;
        slow_clk_in = 1'b0;
        forever begin
            @(posedge clock);
            slow_div_q  <= slow_div_q + 5'h01;
            slow_clk_in <= slow_div_q[4];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_req.addr    <= a;
        reg_req.wr_data <= d;
        reg_req.wr_en   <= 1'b1;
        @(posedge clock);
        reg_req.wr_en   <= 1'b0;
    endtask

    // Read data is taken in the single cycle after the strobe
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_req.addr  <= a;
        reg_req.rd_en <= 1'b1;
        @(posedge clock);
        reg_req.rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic do_reset(input logic por, input logic by_wdog);
        @(posedge clock);
        reset_n       <= 1'b0;
        por_n         <= ~por;
        reset_by_wdog <= by_wdog;
        repeat (5) @(posedge clock);
        reset_n       <= 1'b1;
        por_n         <= 1'b1;
        reset_by_wdog <= 1'b0;
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog against hangs; the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        err_total      = 0;
        tests_run      = 0;
        reset_n        = 1'b0;
        por_n          = 1'b0;
        reset_by_wdog  = 1'b0;
        sys_irq_enable = 1'b0;
        reg_req        = '0;
        void'($urandom(12195));
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        por_n   <= 1'b1;

        // Power-up values, read data lasting one cycle, unmapped read
        rd(ADDR_CONTROL, got);
        chk(got, 32'h0000_0020);
        @(posedge clock);
        #1 chk(rd_data, 32'h0000_0000);
        rd(32'he000_5000, got);
        chk(got, 32'h0000_0000);

        // Mask register holds only bits 11 and 3:0
        for (int i = 0; i < 4; i++) begin
            mask_model = $urandom;
            wr(ADDR_IRQ_MASK, mask_model);
            rd(ADDR_IRQ_MASK, got);
            chk(got, mask_model & 32'h0000_080f);
        end

        // Every run-enable pattern reaches the channel outputs
        for (int i = 0; i < 16; i++) begin
            wr(ADDR_CONTROL, 32'(i) << CTL_RUN_LSB);
            #1 chk({28'h0, chan_run_enable}, 32'(i));
        end

        // Channel 0 runs at the fastest rate, channel 1 is loaded but held
        wr(ADDR_CONTROL, 32'h0000_0000);
        wr(ADDR_CHAN_BASE + CHAN_STRIDE, 32'h0000_0005);
        wr(ADDR_CHAN_BASE, 32'h0000_0003);
        wr(ADDR_CONTROL, 32'h0000_0800);
        repeat (20) @(posedge clock);
        rd(ADDR_STATUS, got);
        chk(got, 32'h0000_0001);
        rd(ADDR_CHAN_BASE + CHAN_STRIDE + CHAN_COUNT_OFS, got);
        chk(got, 32'h0000_0005);
        rd(ADDR_CHAN_BASE + CHAN_COUNT_OFS, got);
        chk(32'(got <= 32'h3), 32'h1);

        // Interrupt forwarding with random masks and system enable
        for (int i = 0; i < 8; i++) begin
            mask_model = ($urandom & 32'h0000_080e) | 32'(i & 1);
            @(posedge clock);
            sys_irq_enable <= 1'($urandom);
            wr(ADDR_IRQ_MASK, mask_model);
            #1 chk(timer_irq_req, mask_model[0]);
            chk(timer_irq, mask_model[0] & sys_irq_enable);
        end

        // Stop the channel, then clear its flag by writing one
        wr(ADDR_CONTROL, 32'h0000_0000);
        wr(ADDR_STATUS, 32'h0000_0001);
        rd(ADDR_STATUS, got);
        chk(got, 32'h0000_0000);
        wr(ADDR_IRQ_MASK, 32'h0000_080f);
        #1 chk(timer_irq_req, 1'b0);

        // Watchdog set up, then clock select and reset scope locked against later writes
        wr(ADDR_CONTROL, 32'h0000_0110);
        wr(ADDR_CONTROL, 32'h0000_0118);
        rd(ADDR_CONTROL, got);
        chk(got, 32'h0000_0118);
        wr(ADDR_CONTROL, 32'h0000_0020);
        rd(ADDR_CONTROL, got);
        chk(got, 32'h0000_0018);

        // Counting, ignored restart value, proper restart value
        repeat (40) @(posedge clock);
        rd(ADDR_WDOG_COUNT, got);
        chk(32'(got > 32'h0 && got < 32'd40), 32'h1);
        wr(ADDR_WDOG_COUNT, 32'h0000_1234);
        rd(ADDR_WDOG_COUNT, got);
        chk(32'(got > 32'd15), 32'h1);
        wr(ADDR_WDOG_COUNT, 32'(WDOG_RESTART));
        rd(ADDR_WDOG_COUNT, got);
        chk(32'(got < 32'd4), 32'h1);
        chk(wdog_reset_req, 1'b0);

        // Reset sources against the reset scope and power-up values
        do_reset(1'b0, 1'b0);
        rd(ADDR_CONTROL, got);
        chk(got, 32'h0000_0018);
        do_reset(1'b0, 1'b1);
        rd(ADDR_CONTROL, got);
        chk(got, 32'h0000_0010);
        do_reset(1'b1, 1'b0);
        rd(ADDR_CONTROL, got);
        chk(got, 32'h0000_0020);

        // Power-up clock select: the watchdog steps once per slow clock period
        wr(ADDR_CONTROL, 32'h0000_0128);
        repeat (160) @(posedge clock);
        rd(ADDR_WDOG_COUNT, got);
        chk(32'(got >= 32'd4 && got <= 32'd6), 32'h1);
        chk(wdog_reset_req, 1'b0);
        finish_test();
    end

endmodule

`default_nettype wire
